// ==== logic/ssrs_pkg.sv ====
/*
  Package of the speed step and run select block: parameter offsets, field codes,
  reset values and the 3-wire run hold time.
  Assumes a 100 MHz system clock and 16-bit parameter words.
*/
// Summary of operation
// - Input with function code 3 is step bit 0; also master/aux1 switch.
// - Input with function code 4 is step bit 1; also aux reference 2 select.
// - Input with function code 5 is step bit 2 for preset selection.
// - Input with function code 6 is jog select, over all step bits.
// - Jog off: step bits form index; preset index+1 is chosen, 1 to 8.
// - All step bits and jog off selects step 1, the master reference.
// - Jog on outputs the jog speed preset regardless of step bits.
// - Step 1 uses master analog when source setting is 1, preset 1 when 0.
// - Step 2 uses aux1 analog when its function is 2, else preset 2.
// - Step 3 uses aux2 analog when its function is 3, else preset 3.
// - Aux1 and aux2 analog functions never equal; equal writes are rejected.
// - Run source 0 keypad, 1 terminals, 2 serial, 3 option; range 0-3; reset 1.
// - 2-wire: run forward while forward input on and reverse off; both on stops.
// - 2-wire: run reverse while reverse input on and forward off, stop when off.
// - Any input function 0 selects 3-wire; that input gives direction.
// - 3-wire initialization assigns multi-function input 3 as direction.
// - 3-wire: run input held 50 ms latches the run command.
package ssrs_pkg;

  // Parameter addresses
  localparam logic [15:0] ADDR_FREQ_SRC   = 16'h0180;
  localparam logic [15:0] ADDR_RUN_SRC    = 16'h0181;
  localparam logic [15:0] ADDR_INIT_MODE  = 16'h0102;
  localparam logic [15:0] ADDR_AUX1_FUNC  = 16'h0410;
  localparam logic [15:0] ADDR_AUX2_FUNC  = 16'h0411;
  localparam logic [15:0] ADDR_FUNC_BASE  = 16'h0400;
  localparam logic [15:0] ADDR_PRESET_BASE = 16'h0280;
  localparam logic [15:0] ADDR_JOG_PRESET = 16'h0290;

  // Counts
  localparam int NUM_CONTACTS = 12;
  localparam int NUM_MULTI    = 10;
  localparam int NUM_PRESETS  = 8;

  // Multi-function input codes
  localparam logic [7:0] FN_DIRECTION = 8'h00;
  localparam logic [7:0] FN_STEP0     = 8'h03;
  localparam logic [7:0] FN_STEP1     = 8'h04;
  localparam logic [7:0] FN_STEP2     = 8'h05;
  localparam logic [7:0] FN_JOG       = 8'h06;
  localparam logic [7:0] FN_NONE      = 8'h0F;

  // Analog function codes
  localparam logic [7:0] AF_AUX1   = 8'h02;
  localparam logic [7:0] AF_AUX2   = 8'h03;
  localparam logic [7:0] AF_UNUSED = 8'h1F;

  // Source codes
  localparam logic [1:0] SRC_KEYPAD   = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_SERIAL   = 2'h2;
  localparam logic [1:0] SRC_OPTION   = 2'h3;
  localparam logic [15:0] RUN_SRC_MAX = 16'h0003;
  localparam logic [15:0] FREQ_SRC_MAX = 16'h0004;
  localparam logic [15:0] INIT_MODE_3WIRE = 16'h0003;
  localparam logic [15:0] FREQ_SRC_ANALOG = 16'h0001;
  localparam logic [3:0]  STEP_JOG        = 4'h9;

  // Reset values
  localparam logic [15:0] RST_RUN_SRC   = 16'h0001;
  localparam logic [15:0] RST_FREQ_SRC  = 16'h0001;
  localparam logic [7:0]  RST_AUX1_FUNC = 8'h1F;
  localparam logic [7:0]  RST_AUX2_FUNC = 8'h00;
  localparam logic [15:0] RST_PRESET    = 16'h0000;
  localparam logic [3:0]  RST_STEP      = 4'h1;
  localparam logic [NUM_MULTI*8-1:0] RST_FUNC_SEL = {
    8'h0F, 8'h0F, 8'h0F, 8'h05, 8'h0F, 8'h06, 8'h04, 8'h03, 8'h0F, 8'h0F};

  // Timing
  localparam longint CLK_HZ         = 100_000_000;
  localparam longint RUN_HOLD_MS    = 50;
  localparam int     RUN_HOLD_CYCLES = int'((RUN_HOLD_MS * CLK_HZ + 999) / 1000);

endpackage : ssrs_pkg

// ==== logic/ssrs_sync_if.sv ====
/*
  Interface between the top and its contact synchronizer.
  Assumes the clock and reset of the top.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssrs_sync_if;
  logic [11:0] raw;
  logic [11:0] synced;
  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : ssrs_sync_if
`default_nettype wire

// ==== logic/ssrs_sync.sv ====
/*
  Two-stage synchronizer for the contact inputs.
  Assumes contacts may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrs_sync (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Contacts
  ssrs_sync_if.sync  port
);
  typedef struct packed {
    logic [11:0] stage1;
    logic [11:0] stage2;
  } ssrs_sync_state_t;

  ssrs_sync_state_t state_reg;
  ssrs_sync_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = port.raw;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.synced = state_reg.stage2;
endmodule : ssrs_sync
`default_nettype wire

// ==== logic/ssrs_top.sv ====
/*
  Speed step and run select of a motor drive: preset and jog speed selection
  from contact inputs, and 2-wire or 3-wire terminal run sequencing.
  Assumes parameters are written over a simple word port, contacts are raw
  switches, and analog inputs arrive already scaled.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrs_top #(
  parameter int unsigned RUN_HOLD_CYCLES = ssrs_pkg::RUN_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Parameter access
  input  wire logic        paramWrEn,
  input  wire logic        paramRdEn,
  input  wire logic [15:0] paramAddr,
  input  wire logic [15:0] paramWrData,
  output logic      [15:0] paramRdData,
  output logic             paramReject,
  // Contacts S1..S12, bit 0 is the forward run input
  input  wire logic [11:0] contactIn,
  // Analog references
  input  wire logic [15:0] masterAnalogInput,
  input  wire logic [15:0] aux1AnalogInput,
  input  wire logic [15:0] aux2AnalogInput,
  // Speed selection
  output logic      [15:0] speedRef,
  output logic      [3:0]  speedStep,
  output logic             jogActive,
  output logic             auxRef2Select,
  // Run control
  output logic      [3:0]  runSourceOneHot,
  output logic             threeWireMode,
  output logic             terminalRun,
  output logic             terminalReverse
);

  typedef struct packed {
    logic [15:0]                              freqSrc;
    logic [15:0]                              runSrc;
    logic [15:0]                              initMode;
    logic [7:0]                               aux1Func;
    logic [7:0]                               aux2Func;
    logic [ssrs_pkg::NUM_MULTI-1:0][7:0]      funcSel;
    logic [ssrs_pkg::NUM_PRESETS:0][15:0]     preset;
    logic [15:0]                              rdData;
    logic                                     reject;
    logic [31:0]                              holdCnt;
    logic                                     runLatch;
    logic [15:0]                              speed;
    logic [3:0]                               step;
    logic                                     jog;
    logic                                     auxSel2;
    logic                                     run;
    logic                                     reverse;
    logic                                     threeWire;
  } ssrs_state_t;

  ssrs_state_t  state_reg;
  ssrs_state_t  state_next;
  ssrs_sync_if  syncPort ();

  assign syncPort.raw = contactIn;

  ssrs_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .port (syncPort.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Contact decode
  logic [11:0] contacts;
  logic        stepBit0;
  logic        stepBit1;
  logic        stepBit2;
  logic        jogSel;
  logic        dirCmd;
  logic        anyDirFunc;
  logic [2:0]  stepIdx;

  assign contacts = syncPort.synced;

  always_comb begin
    stepBit0   = 1'b0;
    stepBit1   = 1'b0;
    stepBit2   = 1'b0;
    jogSel     = 1'b0;
    dirCmd     = 1'b0;
    anyDirFunc = 1'b0;
    for (int i = 0; i < ssrs_pkg::NUM_MULTI; i++) begin
      unique case (state_reg.funcSel[i])
        ssrs_pkg::FN_STEP0: stepBit0 = stepBit0 | contacts[i+2];
        ssrs_pkg::FN_STEP1: stepBit1 = stepBit1 | contacts[i+2];
        ssrs_pkg::FN_STEP2: stepBit2 = stepBit2 | contacts[i+2];
        ssrs_pkg::FN_JOG: jogSel = jogSel | contacts[i+2];
        ssrs_pkg::FN_DIRECTION: begin
          anyDirFunc = 1'b1;
          dirCmd     = dirCmd | contacts[i+2];
        end
        default: begin
        end
      endcase
    end
  end

  assign stepIdx = {stepBit2, stepBit1, stepBit0};

  ////////////////////////////////////////////////////////////////////////////
  // Speed selection
  logic [15:0] stepValue;

  always_comb begin
    stepValue = state_reg.preset[stepIdx];
    unique case (stepIdx)
      3'h0: begin
        if (state_reg.freqSrc == ssrs_pkg::FREQ_SRC_ANALOG) begin
          stepValue = masterAnalogInput;
        end
      end
      3'h1: begin
        if (state_reg.aux1Func == ssrs_pkg::AF_AUX1) begin
          stepValue = aux1AnalogInput;
        end
      end
      3'h2: begin
        if (state_reg.aux2Func == ssrs_pkg::AF_AUX2) begin
          stepValue = aux2AnalogInput;
        end
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter access, run sequencing and output registers
  logic [15:0] offFunc;
  logic [15:0] offPreset;
  logic        hitRunSrc;
  logic        hitFreqSrc;
  logic        hitAux1;
  logic        hitAux2;
  logic        hitInit;
  logic        hitFunc;
  logic        hitPreset;
  logic        hitJog;

  // One decode serves both the write and the read path
  assign offFunc    = paramAddr - ssrs_pkg::ADDR_FUNC_BASE;
  assign offPreset  = paramAddr - ssrs_pkg::ADDR_PRESET_BASE;
  assign hitRunSrc  = (paramAddr == ssrs_pkg::ADDR_RUN_SRC);
  assign hitFreqSrc = (paramAddr == ssrs_pkg::ADDR_FREQ_SRC);
  assign hitAux1    = (paramAddr == ssrs_pkg::ADDR_AUX1_FUNC);
  assign hitAux2    = (paramAddr == ssrs_pkg::ADDR_AUX2_FUNC);
  assign hitInit    = (paramAddr == ssrs_pkg::ADDR_INIT_MODE);
  assign hitFunc    = (offFunc < 16'(ssrs_pkg::NUM_MULTI));
  assign hitPreset  = (offPreset < 16'(ssrs_pkg::NUM_PRESETS));
  assign hitJog     = (paramAddr == ssrs_pkg::ADDR_JOG_PRESET);

  always_comb begin
    state_next        = state_reg;
    state_next.reject = 1'b0;

    // Writes
    if (paramWrEn) begin
      if (hitRunSrc) begin
        if (paramWrData <= ssrs_pkg::RUN_SRC_MAX) begin
          state_next.runSrc = paramWrData;
        end else begin
          state_next.reject = 1'b1;
        end
      end else if (hitFreqSrc) begin
        if (paramWrData <= ssrs_pkg::FREQ_SRC_MAX) begin
          state_next.freqSrc = paramWrData;
        end else begin
          state_next.reject = 1'b1;
        end
      end else if (hitAux1) begin
        if (paramWrData[7:0] == state_reg.aux2Func) begin
          state_next.reject = 1'b1;
        end else begin
          state_next.aux1Func = paramWrData[7:0];
        end
      end else if (hitAux2) begin
        if (paramWrData[7:0] == state_reg.aux1Func) begin
          state_next.reject = 1'b1;
        end else begin
          state_next.aux2Func = paramWrData[7:0];
        end
      end else if (hitInit) begin
        state_next.initMode = paramWrData;
        if (paramWrData == ssrs_pkg::INIT_MODE_3WIRE) begin
          state_next.funcSel[0] = ssrs_pkg::FN_DIRECTION;
        end
      end else if (hitFunc) begin
        state_next.funcSel[offFunc[3:0]] = paramWrData[7:0];
      end else if (hitPreset) begin
        state_next.preset[offPreset[3:0]] = paramWrData;
      end else if (hitJog) begin
        state_next.preset[ssrs_pkg::NUM_PRESETS] = paramWrData;
      end else begin
        state_next.reject = 1'b1;
      end
    end

    // Reads, unmapped addresses read zero
    if (paramRdEn) begin
      state_next.rdData = 16'h0000;
      if (hitRunSrc) begin
        state_next.rdData = state_reg.runSrc;
      end else if (hitFreqSrc) begin
        state_next.rdData = state_reg.freqSrc;
      end else if (hitAux1) begin
        state_next.rdData = {8'h00, state_reg.aux1Func};
      end else if (hitAux2) begin
        state_next.rdData = {8'h00, state_reg.aux2Func};
      end else if (hitInit) begin
        state_next.rdData = state_reg.initMode;
      end else if (hitFunc) begin
        state_next.rdData = {8'h00, state_reg.funcSel[offFunc[3:0]]};
      end else if (hitPreset) begin
        state_next.rdData = state_reg.preset[offPreset[3:0]];
      end else if (hitJog) begin
        state_next.rdData = state_reg.preset[ssrs_pkg::NUM_PRESETS];
      end
    end

    // Speed reference
    state_next.jog     = jogSel;
    state_next.auxSel2 = stepBit1 && (state_reg.aux2Func == ssrs_pkg::AF_AUX2);
    if (jogSel) begin
      state_next.speed = state_reg.preset[ssrs_pkg::NUM_PRESETS];
      state_next.step  = ssrs_pkg::STEP_JOG;
    end else begin
      state_next.speed = stepValue;
      state_next.step  = {1'b0, stepIdx} + 4'h1;
    end

    // Run sequencing on the terminals
    state_next.threeWire = anyDirFunc;
    if (!anyDirFunc) begin
      state_next.holdCnt  = 32'h0000_0000;
      state_next.runLatch = 1'b0;
      state_next.run      = contacts[0] ^ contacts[1];
      state_next.reverse  = contacts[1] & ~contacts[0];
    end else begin
      if (!contacts[1]) begin
        state_next.holdCnt  = 32'h0000_0000;
        state_next.runLatch = 1'b0;
      end else if (contacts[0] && !state_reg.runLatch) begin
        if (state_reg.holdCnt >= 32'(RUN_HOLD_CYCLES - 1)) begin
          state_next.runLatch = 1'b1;
        end else begin
          state_next.holdCnt = state_reg.holdCnt + 32'h0000_0001;
        end
      end else if (!contacts[0]) begin
        state_next.holdCnt = 32'h0000_0000;
      end
      state_next.run     = state_next.runLatch;
      state_next.reverse = dirCmd;
    end
    if (state_reg.runSrc[1:0] != ssrs_pkg::SRC_TERMINAL) begin
      state_next.run     = 1'b0;
      state_next.reverse = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg          <= '0;
      state_reg.freqSrc  <= ssrs_pkg::RST_FREQ_SRC;
      state_reg.runSrc   <= ssrs_pkg::RST_RUN_SRC;
      state_reg.aux1Func <= ssrs_pkg::RST_AUX1_FUNC;
      state_reg.aux2Func <= ssrs_pkg::RST_AUX2_FUNC;
      state_reg.funcSel  <= ssrs_pkg::RST_FUNC_SEL;
      state_reg.step     <= ssrs_pkg::RST_STEP;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    runSourceOneHot = 4'h0;
    runSourceOneHot[state_reg.runSrc[1:0]] = 1'b1;
  end

  assign paramRdData     = state_reg.rdData;
  assign paramReject     = state_reg.reject;
  assign speedRef        = state_reg.speed;
  assign speedStep       = state_reg.step;
  assign jogActive       = state_reg.jog;
  assign auxRef2Select   = state_reg.auxSel2;
  assign threeWireMode   = state_reg.threeWire;
  assign terminalRun     = state_reg.run;
  assign terminalReverse = state_reg.reverse;

endmodule : ssrs_top
`default_nettype wire

// ==== test/ssrs_top_props.sv ====
/*
  Checker of the speed step and run select top.
  Assumes binding to ssrs_top; it sees the top's ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrs_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Parameter access
  input wire logic        paramWrEn,
  input wire logic        paramRdEn,
  input wire logic [15:0] paramAddr,
  input wire logic [15:0] paramWrData,
  input wire logic [15:0] paramRdData,
  input wire logic        paramReject,
  // Contacts and outputs
  input wire logic [11:0] contactIn,
  input wire logic [3:0]  speedStep,
  input wire logic        jogActive,
  input wire logic [3:0]  runSourceOneHot,
  input wire logic        threeWireMode,
  input wire logic        terminalRun,
  input wire logic        terminalReverse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Stop contact opens and the mode stays for the sync delay
  sequence s_stop_open;
    threeWireMode && !contactIn[1] ##1 threeWireMode [*3];
  endsequence
  sequence s_two_wire;
    (runSourceOneHot[1] && !threeWireMode) [*4];
  endsequence
  property p_jog_step;
    jogActive |-> speedStep == 4'h9;
  endproperty
  property p_src_onehot;
    $onehot(runSourceOneHot);
  endproperty
  property p_src_gate;
    !runSourceOneHot[1] [*2] |-> !terminalRun && !terminalReverse;
  endproperty
  property p_rd_run;
    paramRdEn && !paramWrEn && paramAddr == ssrs_pkg::ADDR_RUN_SRC
      |=> runSourceOneHot == (4'h1 << paramRdData[1:0]) && paramRdData[15:2] == 14'h0;
  endproperty
  property p_run_range;
    paramWrEn && paramAddr == ssrs_pkg::ADDR_RUN_SRC && paramWrData > ssrs_pkg::RUN_SRC_MAX |=> paramReject;
  endproperty
  property p_reject_cause;
    paramReject |-> $past(paramWrEn);
  endproperty
  property p_two_wire;
    s_two_wire |-> terminalRun == ($past(contactIn[0], 3) ^ $past(contactIn[1], 3))
      && terminalReverse == ($past(contactIn[1], 3) && !$past(contactIn[0], 3));
  endproperty
  property p_stop;
    s_stop_open |-> !terminalRun;
  endproperty
  a_jog_step: assert property (p_jog_step) else $error("jog without step 9");
  a_src_onehot: assert property (p_src_onehot) else $error("run source not one-hot");
  a_src_gate: assert property (p_src_gate) else $error("run outside terminal source");
  a_rd_run: assert property (p_rd_run) else $error("run source read mismatch");
  a_run_range: assert property (p_run_range) else $error("run source range not refused");
  a_reject_cause: assert property (p_reject_cause) else $error("refusal without write");
  a_two_wire: assert property (p_two_wire) else $error("2-wire run wrong");
  a_stop: assert property (p_stop) else $error("run held with stop open");
endmodule : ssrs_props
bind ssrs_top ssrs_props u_props (.clk, .rst, .paramWrEn, .paramRdEn, .paramAddr, .paramWrData,
  .paramRdData, .paramReject, .contactIn, .speedStep, .jogActive, .runSourceOneHot,
  .threeWireMode, .terminalRun, .terminalReverse);
`default_nettype wire

// ==== test/ssrs_contact_bank.sv ====
/*
  Contact panel model: switches moved by a controller.
  Assumes the sequence gives the wanted contact state.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrs_contact_bank (
  // Clock
  input  wire logic        clk,
  // Wanted contact state
  input  wire logic [11:0] closeReq,
  // Contacts at the drive
  output var  logic [11:0] contactIn
);
  // Contacts move away from the sampling edge
  always @(negedge clk) contactIn <= closeReq;
endmodule : ssrs_contact_bank
`default_nettype wire

// ==== test/test_speed_step_and_run_select.sv ====
/*
  Self-checking bench of the speed step and run select top.
  Assumes the contact bank model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_speed_step_and_run_select;
  localparam int HOLD = 8;
  logic        clk, rst, paramWrEn, paramRdEn, paramReject, rj;
  logic        jogActive, auxRef2Select, threeWireMode, terminalRun, terminalReverse;
  logic [15:0] paramAddr, paramWrData, paramRdData, speedRef, got;
  logic [11:0] closeReq, contactIn;
  logic [3:0]  speedStep, runSourceOneHot;
  int          numErrors, checks, s;
  ssrs_contact_bank bank (.clk(clk), .closeReq(closeReq), .contactIn(contactIn));
  ssrs_top #(.RUN_HOLD_CYCLES(HOLD)) uut (.clk(clk), .rst(rst), .paramWrEn(paramWrEn),
    .paramRdEn(paramRdEn), .paramAddr(paramAddr), .paramWrData(paramWrData),
    .paramRdData(paramRdData), .paramReject(paramReject), .contactIn(contactIn),
    .masterAnalogInput(16'h3C3C), .aux1AnalogInput(16'h5A00), .aux2AnalogInput(16'h00A5),
    .speedRef(speedRef), .speedStep(speedStep), .jogActive(jogActive),
    .auxRef2Select(auxRef2Select), .runSourceOneHot(runSourceOneHot),
    .threeWireMode(threeWireMode), .terminalRun(terminalRun), .terminalReverse(terminalReverse));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Refusal shows from the taking edge and lasts one cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    paramWrEn   = 1'b1;
    paramAddr   = a;
    paramWrData = d;
    @(negedge clk);
    paramWrEn = 1'b0;
    rj        = paramReject;
    @(negedge clk);
    rj = rj & ~paramReject;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    paramRdEn = 1'b1;
    paramAddr = a;
    @(negedge clk);
    paramRdEn = 1'b0;
    @(negedge clk);
    got = paramRdData;
  endtask : rd
  task automatic setc(input logic [11:0] c);
    closeReq = c;
    repeat (5) @(negedge clk);
  endtask : setc
  function automatic logic [11:0] steps(input int i);
    return {3'b0, i[2], 2'b0, i[1], i[0], 4'b0};
  endfunction : steps
  task automatic complete_run;
    if (numErrors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500_000;
    numErrors++;
    complete_run();
  end
  initial begin
    rst         = 1'b1;
    paramWrEn   = 1'b0;
    paramRdEn   = 1'b0;
    paramAddr   = 16'h0000;
    paramWrData = 16'h0000;
    closeReq    = 12'h000;
    numErrors   = 0;
    checks      = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(ssrs_pkg::ADDR_RUN_SRC);
    chk("runSrc", 16'h0001, got);
    chk("step", 16'h0001, 16'(speedStep));
    wr(ssrs_pkg::ADDR_FREQ_SRC, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(ssrs_pkg::ADDR_PRESET_BASE + 16'(i), 16'h0100 + 16'(i));
    end
    wr(ssrs_pkg::ADDR_JOG_PRESET, 16'h0A5A);
    for (int i = 0; i < 8; i++) begin
      setc(steps(i));
      chk("step", 16'(i + 1), 16'(speedStep));
      chk("ref", 16'h0100 + 16'(i), speedRef);
    end
    setc(steps(7) | 12'h040);
    chk("step", 16'h0009, 16'(speedStep));
    chk("jog", 16'h0001, 16'(jogActive));
    chk("ref", 16'h0A5A, speedRef);
    wr(ssrs_pkg::ADDR_FREQ_SRC, 16'h0001);
    setc(steps(0));
    chk("jog", 16'h0000, 16'(jogActive));
    chk("ref", 16'h3C3C, speedRef);
    wr(ssrs_pkg::ADDR_AUX1_FUNC, 16'h0002);
    setc(steps(1));
    chk("ref", 16'h5A00, speedRef);
    wr(ssrs_pkg::ADDR_AUX2_FUNC, 16'h0003);
    chk("reject", 16'h0000, 16'(rj));
    setc(steps(2));
    chk("ref", 16'h00A5, speedRef);
    chk("aux2Sel", 16'h0001, 16'(auxRef2Select));
    setc(steps(4));
    chk("step", 16'h0005, 16'(speedStep));
    chk("aux2Sel", 16'h0000, 16'(auxRef2Select));
    wr(ssrs_pkg::ADDR_AUX1_FUNC, 16'h0003);
    chk("reject", 16'h0001, 16'(rj));
    rd(ssrs_pkg::ADDR_AUX1_FUNC);
    chk("aux1Func", 16'h0002, got);
    wr(ssrs_pkg::ADDR_RUN_SRC, 16'h0004);
    chk("reject", 16'h0001, 16'(rj));
    for (int k = 0; k < 4; k++) begin
      s = (k + 2) % 4;
      wr(ssrs_pkg::ADDR_RUN_SRC, 16'(s));
      setc(12'h001);
      chk("oneHot", 16'h0001 << s, 16'(runSourceOneHot));
      chk("run", 16'(s == 1), 16'(terminalRun));
    end
    chk("rev", 16'h0000, 16'(terminalReverse));
    setc(12'h000);
    chk("run", 16'h0000, 16'(terminalRun));
    setc(12'h002);
    chk("run", 16'h0001, 16'(terminalRun));
    chk("rev", 16'h0001, 16'(terminalReverse));
    setc(12'h000);
    chk("run", 16'h0000, 16'(terminalRun));
    // Function select is set before the 3-wire contacts are used
    wr(ssrs_pkg::ADDR_INIT_MODE, ssrs_pkg::INIT_MODE_3WIRE);
    rd(ssrs_pkg::ADDR_FUNC_BASE);
    chk("dirFunc", 16'h0000, got);
    setc(12'h002);
    chk("threeWire", 16'h0001, 16'(threeWireMode));
    setc(12'h003);
    setc(12'h002);
    chk("run", 16'h0000, 16'(terminalRun));
    closeReq = 12'h003;
    repeat (HOLD + 4) @(negedge clk);
    setc(12'h002);
    chk("run", 16'h0001, 16'(terminalRun));
    setc(12'h006);
    chk("rev", 16'h0001, 16'(terminalReverse));
    setc(12'h000);
    chk("run", 16'h0000, 16'(terminalRun));
    // A reset after the run has stopped brings back the default settings
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(ssrs_pkg::ADDR_RUN_SRC);
    chk("runSrc", 16'h0001, got);
    chk("threeWire", 16'h0000, 16'(threeWireMode));
    chk("step", 16'h0001, 16'(speedStep));
    complete_run();
  end
endmodule : test_speed_step_and_run_select
`default_nettype wire
